// File: core/regfile_pkg.sv
package regfile_pkg;
  localparam int unsigned num_regs = 32;
  localparam logic [15:0] io_base = 16'h0020;
  localparam logic [15:0] sram_base = 16'h0060;
  localparam logic [15:0] internal_top = 16'h045f;
  localparam logic [4:0] imm_reg_base = 5'h10;
  localparam logic [4:0] x_lo_idx = 5'h1a;
  localparam logic [4:0] y_lo_idx = 5'h1c;
  localparam logic [4:0] z_lo_idx = 5'h1e;
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam logic [12:0] pc_reset_value = 13'h0000;
  localparam logic [2:0] ext_extra_nowait = 3'h1;
  localparam logic [2:0] ext_extra_wait = 3'h2;

  typedef enum logic [2:0]
  {
    mode_none = 3'b000,
    mode_direct = 3'b001,
    mode_io = 3'b010,
    mode_indirect = 3'b011,
    mode_displace = 3'b100,
    mode_predec = 3'b101,
    mode_postinc = 3'b110
  } data_mode_t;

  typedef enum logic [2:0]
  {
    pc_step = 3'b000,
    pc_relative = 3'b001,
    pc_indirect = 3'b010,
    pc_absolute = 3'b011,
    pc_hold = 3'b100
  } pc_mode_t;

  typedef enum logic [1:0]
  {
    ptr_x = 2'b00,
    ptr_y = 2'b01,
    ptr_z = 2'b10
  } ptr_sel_t;

  typedef enum logic [1:0]
  {
    region_regs = 2'b00,
    region_io = 2'b01,
    region_sram = 2'b10,
    region_ext = 2'b11
  } region_t;
endpackage : regfile_pkg

// File: core/reg_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Working register storage: two combinational read ports, one data write port and a
// pointer write port that updates a register pair in the same cycle.
module reg_bank
  import regfile_pkg::*;
#(
  parameter int unsigned depth = 32
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic ptr_wr_en,
  input wire logic [4:0] ptr_wr_addr,
  input wire logic [15:0] ptr_wr_data,
  output logic [7:0] regs_out [depth]
);
  logic [7:0] mem_r [depth];

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < depth; i++)
        mem_r[i] <= reg_reset_value;
    end
    else if (clk_en)
    begin
      if (wr_en)
        mem_r[wr_addr] <= wr_data;
      // Pointer update follows the data write so it wins on overlap.
      if (ptr_wr_en)
      begin
        mem_r[ptr_wr_addr] <= ptr_wr_data[7:0];
        mem_r[ptr_wr_addr + 5'd1] <= ptr_wr_data[15:8];
      end
    end
  end

  assign rd_data_a = mem_r[rd_addr_a];
  assign rd_data_b = mem_r[rd_addr_b];
  assign regs_out = mem_r;
endmodule : reg_bank
`default_nettype wire

// File: core/cpu_regfile_addr.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - Immediate-operand ops address only registers 16 to 31 via a 4-bit field.
// RULE2 - Data addresses 0 to 31 read and write the working registers themselves.
// RULE3 - Registers 26 to 31 form the X, Y and Z 16-bit pointers.
// RULE4 - Addresses below 96 go to registers and I/O, next 1K to internal SRAM.
// RULE5 - Every addressing mode can reach registers, all 64 I/O and internal SRAM; here mode_io reaches only the 64 I/O addresses.
// RULE6 - Addresses above internal SRAM go to external memory, up to 64K - 1.
// RULE7 - External read and write strobes stay inactive during internal accesses.
// RULE8 - External memory works only while the external memory enable bit is set.
// RULE9 - An external byte costs one cycle more than an internal SRAM access.
// RULE10 - Calls, returns and interrupts with external stack take two extra cycles.
// RULE11 - With a wait state each external byte costs two extra cycles.
// RULE12 - Displacement mode adds an unsigned six-bit offset to Y or Z.
// RULE13 - I/O direct takes a six-bit I/O address plus a register field.
// RULE14 - Direct mode takes a 16-bit address from the second instruction word.
// RULE15 - Plain indirect uses the pointer contents unchanged.
// RULE16 - Pre-decrement lowers the pointer first, uses and stores the new value.
// RULE17 - Post-increment uses the old pointer value, then stores it plus one.
// RULE18 - Constant load uses Z upper 15 bits as word, bit 0 as byte select.
// RULE19 - Indirect jump and call load the program counter from Z.
// RULE20 - Relative jump and call go to PC plus signed offset plus one.
// RULE21 - Absolute jump and call load the address carried in the instruction.
// RULE22 - The program counter is 13 bits, covering 8K words.
// RULE23 - Two-register operations read both sources and write the destination.
// RULE24 - I/O registers seen in data space sit at I/O address plus 0x20.
// RULE25 - Register reads and write-backs complete in one cycle.
module cpu_regfile_addr
  import regfile_pkg::*;
#(
  parameter int unsigned pc_width = 13
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [4:0] src_d_idx,
  input wire logic [4:0] src_r_idx,
  input wire logic imm_op,
  input wire logic [3:0] imm_d_idx,
  output logic [7:0] operand_d,
  output logic [7:0] operand_r,
  input wire logic result_we,
  input wire logic [7:0] result_data,
  input wire regfile_pkg::data_mode_t data_mode,
  input wire regfile_pkg::ptr_sel_t ptr_sel,
  input wire logic [5:0] disp_field,
  input wire logic [5:0] io_field,
  input wire logic [15:0] second_word,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata,
  output logic [15:0] data_addr,
  output regfile_pkg::region_t data_region,
  output logic [5:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  output logic sram_rd,
  output logic sram_wr,
  output logic [7:0] sram_wdata,
  input wire logic [7:0] sram_rdata,
  output logic [7:0] mem_rdata,
  output logic mem_rdata_valid,
  input wire logic external_memory_enable_bit,
  input wire logic ext_wait_enable,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic [15:0] ext_addr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata,
  output logic ext_fault,
  input wire logic stack_ext,
  input wire logic pc_push_pop,
  output logic [2:0] extra_cycles,
  output logic stall,
  input wire logic program_constant_load_op,
  output logic [pc_width-1:0] const_word_addr,
  output logic const_high_byte,
  input wire regfile_pkg::pc_mode_t pc_mode,
  input wire logic [11:0] rel_offset,
  input wire logic [pc_width-1:0] abs_target,
  output logic [pc_width-1:0] pc
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] regs [num_regs];
  logic [4:0] dest_idx;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] addr_nxt;
  logic ptr_we;
  logic [15:0] ptr_new;
  logic mem_access;
  logic reg_target;
  logic [7:0] reg_rd_unused;
  logic [2:0] wait_r;
  logic ext_busy_r;
  logic [15:0] ext_addr_r;
  logic ext_is_write_r;
  logic [pc_width-1:0] pc_r;
  logic [7:0] mem_rdata_r;
  logic mem_rdata_valid_r;
  logic region_rd_r;
  region_t region_q_r;
  logic [4:0] reg_rd_idx_r;
  logic ext_start;
  logic [7:0] ext_wdata_r;

  // Immediate forms carry only four index bits, so the upper half of the bank is implied.
  assign dest_idx = imm_op ? {1'b1, imm_d_idx} : src_d_idx; // RULE1

  // Pointer pairs keep the low byte at the even index.
  always_comb
  begin
    unique case (ptr_sel)
      ptr_x: ptr_lo = x_lo_idx;
      ptr_y: ptr_lo = y_lo_idx;
      ptr_z: ptr_lo = z_lo_idx;
      default: ptr_lo = z_lo_idx;
    endcase
  end

  assign ptr_val = {regs[ptr_lo + 5'd1], regs[ptr_lo]}; // RULE3

  ////////////////////////////////////////////////////////////////////////////
  // Address generation for the data space.
  always_comb
  begin
    addr_nxt = 16'h0000;
    ptr_we = 1'b0;
    ptr_new = ptr_val;
    unique case (data_mode)
      mode_none: addr_nxt = 16'h0000;
      mode_direct: addr_nxt = second_word; // RULE14
      mode_io: addr_nxt = {10'h000, io_field} + io_base; // RULE13 RULE24
      mode_indirect: addr_nxt = ptr_val; // RULE15
      mode_displace: addr_nxt = ptr_val + {10'h000, disp_field}; // RULE12
      mode_predec:
      begin
        ptr_new = ptr_val - 16'h0001; // RULE16
        addr_nxt = ptr_new;
        ptr_we = 1'b1;
      end
      mode_postinc:
      begin
        addr_nxt = ptr_val; // RULE17
        ptr_new = ptr_val + 16'h0001;
        ptr_we = 1'b1;
      end
      default: addr_nxt = 16'h0000;
    endcase
  end

  assign mem_access = clk_en && (data_mode != mode_none) && !stall;
  assign data_addr = addr_nxt;
  assign io_addr = 6'(addr_nxt - io_base);

  always_comb
  begin
    // Anything above the internal top falls to the external bus.
    // RULE4 RULE5 RULE6
    if (addr_nxt < io_base)
      data_region = region_regs;
    else if (addr_nxt < sram_base)
      data_region = region_io;
    else if (addr_nxt <= internal_top)
      data_region = region_sram;
    else
      data_region = region_ext;
  end

  // Stores to addresses 0..31 land in the working registers.
  assign reg_target = mem_access && mem_write && (data_region == region_regs); // RULE2

  ////////////////////////////////////////////////////////////////////////////
  reg_bank #(
    .depth(num_regs)
  ) u_bank (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .rd_addr_a(dest_idx),
    .rd_addr_b(src_r_idx),
    .rd_data_a(operand_d),
    .rd_data_b(operand_r),
    .wr_en((result_we && !stall) || reg_target), // RULE23 RULE25
    .wr_addr(reg_target ? addr_nxt[4:0] : dest_idx),
    .wr_data(reg_target ? mem_wdata : result_data),
    .ptr_wr_en(mem_access && ptr_we), // RULE16 RULE17
    .ptr_wr_addr(ptr_lo),
    .ptr_wr_data(ptr_new),
    .regs_out(regs)
  );

  assign reg_rd_unused = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Internal strobes, one cycle wide.
  assign io_rd = mem_access && !mem_write && (data_region == region_io);
  assign io_wr = mem_access && mem_write && (data_region == region_io);
  assign io_wdata = mem_wdata;
  assign sram_rd = mem_access && !mem_write && (data_region == region_sram);
  assign sram_wr = mem_access && mem_write && (data_region == region_sram);
  assign sram_wdata = mem_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // External access sequencer: holds the core while extra cycles elapse.
  // Address and write data are captured at the request so they stand for the whole stall.
  assign ext_start = mem_access && data_region == region_ext
                     && external_memory_enable_bit; // RULE8

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ext_busy_r <= 1'b0;
      wait_r <= 3'h0;
      ext_addr_r <= 16'h0000;
      ext_is_write_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ext_start)
      begin
        ext_busy_r <= 1'b1;
        wait_r <= ext_wait_enable ? ext_extra_wait : ext_extra_nowait; // RULE9 RULE11
        ext_addr_r <= addr_nxt;
        ext_is_write_r <= mem_write;
      end
      else if (ext_busy_r)
      begin
        wait_r <= wait_r - 3'h1;
        if (wait_r == 3'h1)
          ext_busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ext_wdata_r <= 8'h00;
    else if (clk_en && ext_start)
      ext_wdata_r <= mem_wdata;
  end

  assign stall = ext_busy_r;
  assign ext_addr = ext_addr_r;
  assign ext_wdata = ext_wdata_r;
  // Strobes only move while an external cycle is open.
  assign ext_rd_n = !(ext_busy_r && !ext_is_write_r); // RULE7
  assign ext_wr_n = !(ext_busy_r && ext_is_write_r); // RULE7
  assign ext_fault = mem_access && data_region == region_ext
                     && !external_memory_enable_bit; // RULE8

  // Return-address transfers are only reported here; whoever moves the stack owns that stall.
  // RULE10 RULE11
  always_comb
  begin
    if (stack_ext && pc_push_pop)
      extra_cycles = ext_wait_enable ? 3'(2 * ext_extra_wait) : 3'(2 * ext_extra_nowait);
    else if (mem_access && data_region == region_ext && external_memory_enable_bit)
      extra_cycles = ext_wait_enable ? ext_extra_wait : ext_extra_nowait;
    else
      extra_cycles = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data return, registered.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      region_rd_r <= 1'b0;
      region_q_r <= region_regs;
      reg_rd_idx_r <= 5'h00;
    end
    else if (clk_en)
    begin
      region_rd_r <= mem_access && !mem_write && data_region != region_ext;
      region_q_r <= data_region;
      reg_rd_idx_r <= addr_nxt[4:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mem_rdata_r <= 8'h00;
      mem_rdata_valid_r <= 1'b0;
    end
    else if (clk_en)
    begin
      mem_rdata_valid_r <= 1'b0;
      if (region_rd_r)
      begin
        mem_rdata_valid_r <= 1'b1;
        unique case (region_q_r)
          region_regs: mem_rdata_r <= regs[reg_rd_idx_r]; // RULE2
          region_io: mem_rdata_r <= io_rdata;
          region_sram: mem_rdata_r <= sram_rdata;
          region_ext: mem_rdata_r <= reg_rd_unused;
        endcase
      end
      else if (ext_busy_r && !ext_is_write_r && wait_r == 3'h1)
      begin
        mem_rdata_valid_r <= 1'b1;
        mem_rdata_r <= ext_rdata;
      end
    end
  end

  assign mem_rdata = mem_rdata_r;
  assign mem_rdata_valid = mem_rdata_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Program space addressing.
  // The byte pointer is halved to a word address; bits above the counter width are dropped.
  assign const_word_addr = pc_width'({regs[z_lo_idx + 5'd1], regs[z_lo_idx]} >> 1); // RULE18
  assign const_high_byte = program_constant_load_op & regs[z_lo_idx][0]; // RULE18

  // Relative targets wrap at the top of program memory, as the counter width implies.
  always_ff @(posedge clock)
  begin
    if (srst)
      pc_r <= pc_width'(pc_reset_value);
    else if (clk_en && !stall)
    begin
      unique case (pc_mode)
        pc_step: pc_r <= pc_r + pc_width'(1);
        pc_relative: pc_r <= pc_r + pc_width'({{4{rel_offset[11]}}, rel_offset}) + pc_width'(1); // RULE20
        pc_indirect: pc_r <= pc_width'({regs[z_lo_idx + 5'd1], regs[z_lo_idx]}); // RULE19
        pc_absolute: pc_r <= abs_target; // RULE21
        pc_hold: pc_r <= pc_r;
        default: pc_r <= pc_r;
      endcase
    end
  end

  assign pc = pc_r; // RULE22
endmodule : cpu_regfile_addr
`default_nettype wire

// File: tb/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Returns an address pattern while read is strobed; otherwise its data lines toggle.
module ext_mem_model
(
  input wire logic clock,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata,
  output logic [7:0] last_wr
);
  logic [7:0] last_r = 8'h00;
  assign ext_rdata = ext_rd_n ? ~last_r : (ext_addr[7:0] ^ ext_addr[15:8] ^ 8'h5a);
  always_ff @(posedge clock)
  begin
    last_r <= ext_rdata;
    if (!ext_wr_n)
    begin
      last_wr <= ext_wdata;
    end
  end
endmodule : ext_mem_model
`default_nettype wire

// File: tb/regfile_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module regfile_chk
  import regfile_pkg::*;
#(
  parameter int unsigned pc_width = 13
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire regfile_pkg::data_mode_t data_mode,
  input wire logic mem_write,
  input wire logic [15:0] data_addr,
  input wire regfile_pkg::region_t data_region,
  input wire logic external_memory_enable_bit,
  input wire logic ext_wait_enable,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic ext_fault,
  input wire logic stack_ext,
  input wire logic pc_push_pop,
  input wire logic [2:0] extra_cycles,
  input wire logic stall,
  input wire regfile_pkg::pc_mode_t pc_mode,
  input wire logic [11:0] rel_offset,
  input wire logic [pc_width-1:0] abs_target,
  input wire logic [pc_width-1:0] pc
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  logic req;
  assign req = clk_en && !stall && data_mode != mode_none;
  sequence ext_go;
    req && data_region == region_ext && external_memory_enable_bit;
  endsequence
  chk_int_strobes: assert property (req && data_region != region_ext
    |-> ext_rd_n && ext_wr_n ##1 ext_rd_n && ext_wr_n)
    else $error("external strobe active during an internal access");
  chk_ext_read_len: assert property (ext_go ##0 (!ext_wait_enable && !mem_write)
    |=> !ext_rd_n && stall ##1 !stall)
    else $error("external read length wrong");
  chk_ext_wait_len: assert property (ext_go ##0 ext_wait_enable |=> stall [*2] ##1 !stall)
    else $error("external wait length wrong");
  chk_ext_fault: assert property (req && data_region == region_ext
    && !external_memory_enable_bit |-> ext_fault ##1 !stall && ext_rd_n)
    else $error("disabled external access not dropped");
  chk_low_regions: assert property (req && data_addr < io_base |-> data_region == region_regs)
    else $error("register address misrouted");
  chk_sram_region: assert property (req && data_addr >= sram_base
    && data_addr <= internal_top |-> data_region == region_sram)
    else $error("sram address misrouted");
  chk_pc_relative: assert property (clk_en && !stall && pc_mode == pc_relative
    |=> pc == $past(pc) + pc_width'($signed($past(rel_offset))) + 1'b1)
    else $error("relative target wrong");
  chk_pc_absolute: assert property (clk_en && !stall && pc_mode == pc_absolute
    |=> pc == $past(abs_target))
    else $error("absolute target wrong");
  chk_push_extra: assert property (stack_ext && pc_push_pop
    && external_memory_enable_bit |-> extra_cycles == (ext_wait_enable ? 3'h4 : 3'h2))
    else $error("stack extra cycles wrong");
endmodule : regfile_chk
bind cpu_regfile_addr regfile_chk #(.pc_width(pc_width)) chk_u (.clock, .srst, .clk_en,
  .data_mode, .mem_write, .data_addr, .data_region, .external_memory_enable_bit,
  .ext_wait_enable, .ext_rd_n, .ext_wr_n, .ext_fault, .stack_ext, .pc_push_pop,
  .extra_cycles, .stall, .pc_mode, .rel_offset, .abs_target, .pc);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import regfile_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clk_en, imm_op, result_we, mem_write, external_memory_enable_bit, ext_wait_enable;
  logic stack_ext, pc_push_pop, program_constant_load_op, const_high_byte;
  logic io_rd, io_wr, sram_rd, sram_wr, mem_rdata_valid, ext_rd_n, ext_wr_n, ext_fault, stall;
  logic [4:0] src_d_idx, src_r_idx;
  logic [3:0] imm_d_idx;
  logic [7:0] result_data, mem_wdata, sram_rdata, operand_d, operand_r, io_wdata, sram_wdata;
  logic [7:0] mem_rdata, ext_wdata, ext_rdata, last_wr, io_rdata;
  logic [5:0] disp_field, io_field, io_addr;
  logic [15:0] second_word, data_addr, ext_addr;
  logic [11:0] rel_offset;
  logic [12:0] abs_target, const_word_addr, pc;
  logic [2:0] extra_cycles;
  data_mode_t data_mode;
  ptr_sel_t ptr_sel;
  pc_mode_t pc_mode;
  region_t data_region;
  int error_cnt = 0;
  int samples_checked = 0;
  cpu_regfile_addr dut_u (.clock, .srst, .clk_en, .src_d_idx, .src_r_idx, .imm_op, .imm_d_idx,
    .operand_d, .operand_r, .result_we, .result_data, .data_mode, .ptr_sel, .disp_field,
    .io_field, .second_word, .mem_write, .mem_wdata, .data_addr, .data_region, .io_addr, .io_rd,
    .io_wr, .io_wdata, .io_rdata, .sram_rd, .sram_wr, .sram_wdata, .sram_rdata,
    .mem_rdata, .mem_rdata_valid, .external_memory_enable_bit, .ext_wait_enable, .ext_rd_n,
    .ext_wr_n, .ext_addr, .ext_wdata, .ext_rdata, .ext_fault, .stack_ext, .pc_push_pop,
    .extra_cycles, .stall, .program_constant_load_op, .const_word_addr, .const_high_byte,
    .pc_mode, .rel_offset, .abs_target, .pc);
  ext_mem_model mem_u (.clock, .ext_rd_n, .ext_wr_n, .ext_addr, .ext_wdata, .ext_rdata, .last_wr);
  always #5 clock = ~clock;
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic wreg(input logic [3:0] idx, input logic [7:0] val);
    imm_op = 1'b1;
    imm_d_idx = idx;
    result_data = val;
    result_we = 1'b1;
    tick();
    result_we = 1'b0;
    imm_op = 1'b0;
    tick();
  endtask : wreg
  task automatic t_regs();
    wreg(4'hf, 8'ha5);
    src_d_idx = 5'd31;
    #1 check("r31", operand_d, 8'ha5);
    src_d_idx = 5'd3;
    result_data = 8'h3c;
    result_we = 1'b1;
    tick();
    result_we = 1'b0;
    src_r_idx = 5'd3;
    #1 check("r3", operand_r, 8'h3c);
  endtask : t_regs
  task automatic t_ptr();
    wreg(4'ha, 8'h00);
    wreg(4'hb, 8'h01);
    sram_rdata = 8'h3c;
    ptr_sel = ptr_x;
    data_mode = mode_postinc;
    #1 check("postinc addr", data_addr, 16'h0100);
    check("postinc region", data_region, region_sram);
    check("sram rd", sram_rd, 1'b1);
    tick();
    data_mode = mode_predec;
    #1 check("predec addr", data_addr, 16'h0100);
    tick();
    data_mode = mode_indirect;
    #1 check("indirect addr", data_addr, 16'h0100);
    check("rdata valid", mem_rdata_valid, 1'b1);
    check("rdata", mem_rdata, 8'h3c);
    tick();
    data_mode = mode_none;
  endtask : t_ptr
  task automatic t_z();
    wreg(4'he, 8'h41);
    wreg(4'hf, 8'h00);
    ptr_sel = ptr_z;
    data_mode = mode_displace;
    disp_field = 6'h3f;
    mem_write = 1'b1;
    mem_wdata = 8'h5e;
    program_constant_load_op = 1'b1;
    pc_mode = pc_indirect;
    #1 check("disp addr", data_addr, 16'h0080);
    check("sram wr", sram_wr, 1'b1);
    check("sram wdata", sram_wdata, 8'h5e);
    check("const word", const_word_addr, 13'h0020);
    check("const byte", const_high_byte, 1'b1);
    tick();
    pc_mode = pc_hold;
    data_mode = mode_none;
    program_constant_load_op = 1'b0;
    check("indirect_jump_op pc", pc, 13'h0041);
  endtask : t_z
  task automatic t_direct();
    tick();
    data_mode = mode_io;
    io_field = 6'h3f;
    mem_write = 1'b0;
    io_rdata = 8'hc3;
    #1 check("io data addr", data_addr, 16'h005f);
    check("io addr", io_addr, 6'h3f);
    check("io region", data_region, region_io);
    check("io rd", io_rd, 1'b1);
    tick();
    data_mode = mode_direct;
    second_word = 16'h0025;
    mem_write = 1'b1;
    mem_wdata = 8'h69;
    #1 check("io wr", io_wr, 1'b1);
    check("io wdata", io_wdata, 8'h69);
    check("io wr addr", io_addr, 6'h05);
    tick();
    check("io rdata", mem_rdata, 8'hc3);
    check("io rvalid", mem_rdata_valid, 1'b1);
    second_word = 16'h0005;
    mem_wdata = 8'h77;
    #1 check("direct region", data_region, region_regs);
    tick();
    data_mode = mode_none;
    mem_write = 1'b0;
    src_d_idx = 5'd5;
    #1 check("r5", operand_d, 8'h77);
  endtask : t_direct
  task automatic ext_op(input logic w, input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    ext_wait_enable = w;
    mem_write = wr;
    mem_wdata = d;
    data_mode = mode_direct;
    second_word = a;
    tick();
    data_mode = mode_none;
    check("ext addr", ext_addr, a);
    check("strobe", wr ? ext_wr_n : ext_rd_n, 1'b0);
    while (stall === 1'b1 && n < 8)
    begin
      tick();
      n++;
    end
    check("stall cycles", n, w ? 2 : 1);
    while (!wr && mem_rdata_valid !== 1'b1 && n < 12)
    begin
      tick();
      n++;
    end
    check("ext data", wr ? last_wr : mem_rdata, d);
  endtask : ext_op
  task automatic t_ext();
    external_memory_enable_bit = 1'b1;
    stack_ext = 1'b1;
    pc_push_pop = 1'b1;
    #1 check("extra", extra_cycles, 3'h2);
    ext_wait_enable = 1'b1;
    #1 check("extra wait", extra_cycles, 3'h4);
    ext_op(1'b0, 1'b0, 16'h1000, 8'h4a);
    ext_op(1'b1, 1'b0, 16'h2345, 8'h3c);
    ext_op(1'b0, 1'b1, 16'hffff, 8'h96);
    external_memory_enable_bit = 1'b0;
    mem_write = 1'b0;
    data_mode = mode_direct;
    #1 check("fault", ext_fault, 1'b1);
    tick();
    data_mode = mode_none;
    check("no stall", stall, 1'b0);
  endtask : t_ext
  task automatic t_pc();
    abs_target = 13'h0100;
    pc_mode = pc_absolute;
    tick();
    check("abs pc", pc, 13'h0100);
    pc_mode = pc_relative;
    rel_offset = 12'h800;
    tick();
    check("rel back", pc, 13'h1901);
    rel_offset = 12'h7ff;
    tick();
    pc_mode = pc_hold;
    check("rel wrap", pc, 13'h0101);
  endtask : t_pc
  task automatic t_reset();
    srst = 1'b1;
    tick();
    srst = 1'b0;
    #1 check("pc reset", pc, pc_reset_value);
    check("r5 reset", operand_d, reg_reset_value);
    check("stall reset", stall, 1'b0);
    check("rd strobe reset", ext_rd_n, 1'b1);
    check("wr strobe reset", ext_wr_n, 1'b1);
    check("rvalid reset", mem_rdata_valid, 1'b0);
    tick();
    check("pc held", pc, pc_reset_value);
  endtask : t_reset
  initial
  begin
    {clk_en, imm_op, result_we, mem_write, stack_ext, pc_push_pop} = '0;
    {external_memory_enable_bit, ext_wait_enable, program_constant_load_op} = '0;
    {src_d_idx, src_r_idx, imm_d_idx, result_data, mem_wdata, sram_rdata, io_rdata} = '0;
    {disp_field, io_field, second_word, rel_offset, abs_target} = '0;
    data_mode = mode_none;
    ptr_sel = ptr_x;
    pc_mode = pc_hold;
    clk_en = 1'b1;
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    t_regs();
    t_ptr();
    t_z();
    t_direct();
    t_ext();
    t_pc();
    t_reset();
    give_verdict();
  end
  initial
  begin
    #20000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
